//--- inc/xioe_pkg.sv
/*
  shared constants, modes and helpers of the external i/o event conditioning block.
  assumes a single 100 MHz system clock and a 32-bit axi4-lite register bus.
*/
package xioe_pkg;

  // ------
  // timing
  // ------
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int MIN_PULSE_NS = 500;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCKOUT_MS = 100;
  localparam int LOCKOUT_CYC = LOCKOUT_MS * (CLK_HZ / 1000);
  localparam int TRIG_END_MS = 500;
  localparam int TRIG_END_CYC = TRIG_END_MS * (CLK_HZ / 1000);
  localparam int DB_0P5_NS = 500;
  localparam int DB_1_NS = 1000;
  localparam int DB_2_NS = 2000;
  localparam int DB_5_NS = 5000;
  localparam int DB_10_NS = 10000;
  localparam int COMP_MAX_NS = 2000;
  localparam int COMP_MAX_CYC = COMP_MAX_NS / CLK_NS;

  // ------
  // register map
  // ------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MINW = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int CTRL_EV_MODE = 0;
  localparam int CTRL_OUT_SEL = 1;
  localparam int CTRL_TRIG_END_EN = 3;
  localparam int CTRL_START_MODE = 4;
  localparam int CTRL_STOP_MODE = 6;
  localparam int CTRL_DB_SEL = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] MINW_RST = 16'(MIN_PULSE_CYC);
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  localparam int IRQ_CYCLE = 0;
  localparam int IRQ_ARM = 1;
  localparam int IRQ_START = 2;
  localparam int IRQ_STOP = 3;
  localparam int IRQ_TRIG_END = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------
  // modes and states
  // ------
  typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL} xioe_edge_e;
  typedef enum logic [1:0] {OUT_ALARM, OUT_REC, OUT_TRIG_END} xioe_outsel_e;
  typedef enum logic [2:0] {DB_OFF, DB_0P5, DB_1, DB_2, DB_5, DB_10} xioe_db_e;
  typedef enum logic [1:0] {QS_IDLE, QS_MEASURE, QS_LOCK} xioe_qstate_e;

  // stable-time in cycles of a debounce setting; unknown codes mean off
  function automatic logic [10:0] db_cycles(input logic [2:0] sel);
    case (sel)
      DB_0P5: db_cycles = 11'(DB_0P5_NS / CLK_NS);
      DB_1: db_cycles = 11'(DB_1_NS / CLK_NS);
      DB_2: db_cycles = 11'(DB_2_NS / CLK_NS);
      DB_5: db_cycles = 11'(DB_5_NS / CLK_NS);
      DB_10: db_cycles = 11'(DB_10_NS / CLK_NS);
      default: db_cycles = 11'h000;
    endcase
  endfunction : db_cycles

endpackage : xioe_pkg

//--- hdl/xioe_debounce.sv
/*
  synchroniser and debounce filter for the event input pin.
  assumes the pin is asynchronous to clk_sys; sel comes from clk_sys logic.
*/
`timescale 1ns/10ps
module xioe_debounce (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  input wire logic [2:0] sel,
  output logic level,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic filt;
    logic rise;
    logic [10:0] cnt;
  } xioe_db_s;

  xioe_db_s q, n;
  logic [10:0] need;

  always_comb begin
    n = q;
    need = xioe_pkg::db_cycles(sel);
    n.s1 = pin;
    n.s2 = q.s1;
    n.rise = 1'b0;
    if (q.s2 == q.filt) begin
      n.cnt = 11'h000;
    end else if (need == 11'h000 || q.cnt + 11'h001 >= need) begin
      // level has held for the full filter time
      n.filt = q.s2;
      n.rise = q.s2;
      n.cnt = 11'h000;
    end else begin
      n.cnt = q.cnt + 11'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{s1: 1'b1, s2: 1'b1, filt: 1'b1, rise: 1'b0, cnt: 11'h000};
    end else begin
      q <= n;
    end
  end

  assign level = q.filt;
  assign rise = q.rise;

endmodule : xioe_debounce

//--- hdl/xioe_edge_qual.sv
/*
  start/stop input qualifier: synchroniser, edge select, minimum width, lockout.
  assumes the pin is asynchronous to clk_sys; mode and min_width are clk_sys logic.
*/
`timescale 1ns/10ps
module xioe_edge_qual #(
  parameter int LOCK_CYC = xioe_pkg::LOCKOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin,
  input wire logic [1:0] mode,
  input wire logic [15:0] min_width,
  output logic level,
  output logic evt,
  output logic locked
);

  localparam int CW = ($clog2(LOCK_CYC + 1) > 16) ? $clog2(LOCK_CYC + 1) : 16;

  if (LOCK_CYC < 1) begin : g_chk
    $error("lockout must be at least one cycle");
  end

  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic evt;
    xioe_pkg::xioe_qstate_e st;
    logic [CW-1:0] cnt;
  } xioe_eq_s;

  xioe_eq_s q, n;
  logic target;
  logic active;

  always_comb begin
    n = q;
    n.s1 = pin;
    n.s2 = q.s1;
    n.lvl = q.s2;
    n.evt = 1'b0;
    target = (mode == xioe_pkg::EDGE_RISE);
    active = (mode == xioe_pkg::EDGE_RISE) || (mode == xioe_pkg::EDGE_FALL);
    case (q.st)
      xioe_pkg::QS_IDLE: begin
        if (active && q.lvl != target && q.s2 == target) begin
          n.st = xioe_pkg::QS_MEASURE;
          n.cnt = CW'(1);
        end
      end
      xioe_pkg::QS_MEASURE: begin
        if (!active || q.s2 != target) begin
          n.st = xioe_pkg::QS_IDLE; // [RULE7]
        end else if (q.cnt >= CW'(min_width)) begin
          n.evt = 1'b1; // [RULE5] [RULE6] [RULE7]
          n.st = xioe_pkg::QS_LOCK;
          n.cnt = CW'(1);
        end else begin
          n.cnt = q.cnt + CW'(1);
        end
      end
      xioe_pkg::QS_LOCK: begin
        if (q.cnt >= CW'(LOCK_CYC)) begin
          n.st = xioe_pkg::QS_IDLE; // [RULE8]
        end else begin
          n.cnt = q.cnt + CW'(1);
        end
      end
      default: n.st = xioe_pkg::QS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, evt: 1'b0, st: xioe_pkg::QS_IDLE, cnt: '0};
    end else begin
      q <= n; // [RULE12]
    end
  end

  assign level = q.lvl;
  assign evt = q.evt;
  assign locked = (q.st == xioe_pkg::QS_LOCK);

endmodule : xioe_edge_qual

//--- hdl/xioe_top.sv
/*
  external i/o event conditioning: event input, event output, start/stop inputs,
  axi4-lite registers and one level interrupt.
  assumes pins are asynchronous; alarm, recording, sweep and acquisition signals
  come from logic on clk_sys.
*/
// Notes on behaviour
// (RULE1) event input acts as cycle event or arm
// (RULE2) alarm mode drives output from alarm sources
// (RULE3) recording mode: output high while recording
// (RULE4) trigger end gives one 500 ms pulse
// (RULE5) start input: disabled, rising or falling edge
// (RULE6) stop input: disabled, rising or falling edge
// (RULE7) start/stop pulses under minimum width discarded
// (RULE8) 100 ms lockout for same event kind
// (RULE9) stop after start waits for acquisition begin
// (RULE10) selectable debounce filter on event input
// (RULE11) debounce delay compensated up to 2 us
// (RULE12) all pins pass two synchroniser flops
`timescale 1ns/10ps
module xioe_top #(
  parameter int AW = 8,
  parameter int TRIG_END_CYC = xioe_pkg::TRIG_END_CYC,
  parameter int LOCKOUT_CYC = xioe_pkg::LOCKOUT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic event_in,
  input wire logic start_in,
  input wire logic stop_in,
  output logic event_out,
  // acquisition side
  input wire logic alarm_chan,
  input wire logic alarm_calc,
  input wire logic recording_active,
  input wire logic sweep_done,
  input wire logic acq_started,
  output logic cycle_event,
  output logic [10:0] cycle_event_comp,
  output logic trigger_arm,
  output logic start_req,
  output logic stop_req,
  output logic irq
);

  localparam int TW = $clog2(TRIG_END_CYC + 1);

  if (AW < 5 || TRIG_END_CYC < 1 || LOCKOUT_CYC < 1) begin : g_chk
    $error("address width or timing parameter out of range");
  end

  // ------
  // state
  // ------
  typedef struct packed {
    logic ev_mode;
    logic [1:0] out_sel;
    logic trig_end_en;
    logic [1:0] start_mode;
    logic [1:0] stop_mode;
    logic [2:0] db_sel;
    logic [15:0] min_width;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic aw_ok;
    logic [AW-1:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic start_pend;
    logic stop_pend;
    logic start_req;
    logic stop_req;
    logic cycle_evt;
    logic arm_evt;
    logic [10:0] comp;
    logic [TW-1:0] trig_cnt;
    logic event_out;
  } xioe_top_s;

  xioe_top_s q, n;

  logic ev_level;
  logic ev_rise;
  logic start_level;
  logic start_evt;
  logic start_locked;
  logic stop_level;
  logic stop_evt;
  logic stop_locked;
  logic wr;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] v;
  logic [4:0] irq_set;
  logic [10:0] filt_cyc;
  logic [10:0] comp_cyc;
  logic trig_start;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // ------
  // input conditioning
  // ------
  xioe_debounce u_ev_db (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(event_in),
    .sel(q.db_sel),
    .level(ev_level),
    .rise(ev_rise)
  ); // [RULE10] [RULE12]

  xioe_edge_qual #(.LOCK_CYC(LOCKOUT_CYC)) u_start_q (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(start_in),
    .mode(q.start_mode),
    .min_width(q.min_width),
    .level(start_level),
    .evt(start_evt),
    .locked(start_locked)
  ); // [RULE5] [RULE7] [RULE8]

  xioe_edge_qual #(.LOCK_CYC(LOCKOUT_CYC)) u_stop_q (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin(stop_in),
    .mode(q.stop_mode),
    .min_width(q.min_width),
    .level(stop_level),
    .evt(stop_evt),
    .locked(stop_locked)
  ); // [RULE6] [RULE7] [RULE8]

  // ------
  // register views
  // ------
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[xioe_pkg::CTRL_EV_MODE] = q.ev_mode;
    ctrl_word[xioe_pkg::CTRL_OUT_SEL +: 2] = q.out_sel;
    ctrl_word[xioe_pkg::CTRL_TRIG_END_EN] = q.trig_end_en;
    ctrl_word[xioe_pkg::CTRL_START_MODE +: 2] = q.start_mode;
    ctrl_word[xioe_pkg::CTRL_STOP_MODE +: 2] = q.stop_mode;
    ctrl_word[xioe_pkg::CTRL_DB_SEL +: 3] = q.db_sel;
    status_word = {5'h00, filt_cyc - comp_cyc, 7'h00, q.trig_cnt != '0, q.stop_pend,
                   q.start_pend, stop_locked, start_locked, q.event_out, stop_level,
                   start_level, ev_level};
  end

  // the filter's delay is known, so up to 2 us of it is reported for back-dating
  assign filt_cyc = xioe_pkg::db_cycles(q.db_sel);
  assign comp_cyc = (filt_cyc > 11'(xioe_pkg::COMP_MAX_CYC)) ?
                    11'(xioe_pkg::COMP_MAX_CYC) : filt_cyc; // [RULE11]

  assign trig_start = sweep_done && q.ev_mode && q.trig_end_en; // [RULE4]

  // ------
  // next state
  // ------
  always_comb begin
    n = q;
    v = 32'h0000_0000;
    n.start_req = 1'b0;
    n.stop_req = 1'b0;
    n.cycle_evt = 1'b0;
    n.arm_evt = 1'b0;

    // event input: one source, two uses
    if (ev_rise && !q.ev_mode) begin
      n.cycle_evt = 1'b1; // [RULE1]
      n.comp = comp_cyc; // [RULE11]
    end
    if (ev_rise && q.ev_mode) begin
      n.arm_evt = 1'b1; // [RULE1]
    end

    // start/stop requests; a stop during a pending start is held
    if (start_evt) begin
      n.start_req = 1'b1;
      n.start_pend = 1'b1;
    end
    if (acq_started) begin
      n.start_pend = 1'b0;
    end
    if (stop_evt && (q.start_pend || start_evt) && !acq_started) begin
      n.stop_pend = 1'b1; // [RULE9]
    end else if (stop_evt || (q.stop_pend && acq_started)) begin
      n.stop_req = 1'b1; // [RULE9]
      n.stop_pend = 1'b0;
    end

    // trigger-end pulse timer
    if (trig_start) begin
      n.trig_cnt = TW'(TRIG_END_CYC); // [RULE4]
    end else if (q.trig_cnt != '0) begin
      n.trig_cnt = q.trig_cnt - TW'(1);
    end

    case (q.out_sel)
      xioe_pkg::OUT_ALARM: n.event_out = alarm_chan || alarm_calc; // [RULE2]
      xioe_pkg::OUT_REC: n.event_out = recording_active; // [RULE3]
      xioe_pkg::OUT_TRIG_END: n.event_out = (n.trig_cnt != '0); // [RULE4]
      default: n.event_out = 1'b0;
    endcase

    // axi write channels, taken in either order
    if (s_axi_awvalid && !q.aw_ok) begin
      n.aw_ok = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok) begin
      n.w_ok = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    irq_set = {trig_start, stop_evt, start_evt, ev_rise && q.ev_mode, ev_rise && !q.ev_mode};
    n.irq_stat = q.irq_stat | irq_set;

    if (wr) begin
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = xioe_pkg::RESP_OKAY;
      case (q.aw_addr)
        AW'(xioe_pkg::OFS_CTRL): begin
          v = merge(ctrl_word, q.wdata, q.wstrb);
          n.ev_mode = v[xioe_pkg::CTRL_EV_MODE];
          n.out_sel = v[xioe_pkg::CTRL_OUT_SEL +: 2];
          n.trig_end_en = v[xioe_pkg::CTRL_TRIG_END_EN];
          n.start_mode = v[xioe_pkg::CTRL_START_MODE +: 2];
          n.stop_mode = v[xioe_pkg::CTRL_STOP_MODE +: 2];
          n.db_sel = v[xioe_pkg::CTRL_DB_SEL +: 3];
        end
        AW'(xioe_pkg::OFS_MINW): begin
          v = merge({16'h0000, q.min_width}, q.wdata, q.wstrb);
          n.min_width = v[15:0]; // [RULE7]
        end
        AW'(xioe_pkg::OFS_STATUS): ;
        AW'(xioe_pkg::OFS_IRQ_STAT): begin
          // write one to clear; a new event in the same cycle stays set
          if (q.wstrb[0]) begin
            n.irq_stat = (q.irq_stat & ~q.wdata[4:0]) | irq_set;
          end
        end
        AW'(xioe_pkg::OFS_IRQ_MASK): begin
          v = merge({27'h0, q.irq_mask}, q.wdata, q.wstrb);
          n.irq_mask = v[4:0];
        end
        default: n.bresp = xioe_pkg::RESP_SLVERR;
      endcase
    end

    // axi read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      n.rvalid = 1'b1;
      n.rresp = xioe_pkg::RESP_OKAY;
      case (s_axi_araddr)
        AW'(xioe_pkg::OFS_CTRL): n.rdata = ctrl_word;
        AW'(xioe_pkg::OFS_MINW): n.rdata = {16'h0000, q.min_width};
        AW'(xioe_pkg::OFS_STATUS): n.rdata = status_word;
        AW'(xioe_pkg::OFS_IRQ_STAT): n.rdata = {27'h0, q.irq_stat};
        AW'(xioe_pkg::OFS_IRQ_MASK): n.rdata = {27'h0, q.irq_mask};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = xioe_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  assign wr = q.aw_ok && q.w_ok && !q.bvalid;

  // ------
  // registers
  // ------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ev_mode <= xioe_pkg::CTRL_RST[xioe_pkg::CTRL_EV_MODE];
      q.out_sel <= xioe_pkg::CTRL_RST[xioe_pkg::CTRL_OUT_SEL +: 2];
      q.trig_end_en <= xioe_pkg::CTRL_RST[xioe_pkg::CTRL_TRIG_END_EN];
      q.start_mode <= xioe_pkg::CTRL_RST[xioe_pkg::CTRL_START_MODE +: 2];
      q.stop_mode <= xioe_pkg::CTRL_RST[xioe_pkg::CTRL_STOP_MODE +: 2];
      q.db_sel <= xioe_pkg::CTRL_RST[xioe_pkg::CTRL_DB_SEL +: 3];
      q.min_width <= xioe_pkg::MINW_RST;
      q.irq_mask <= xioe_pkg::IRQ_MASK_RST;
    end else begin
      q <= n;
    end
  end

  // ------
  // outputs
  // ------
  assign s_axi_awready = !q.aw_ok;
  assign s_axi_wready = !q.w_ok;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign event_out = q.event_out;
  assign cycle_event = q.cycle_evt;
  assign cycle_event_comp = q.comp;
  assign trigger_arm = q.arm_evt;
  assign start_req = q.start_req;
  assign stop_req = q.stop_req;
  assign irq = |(q.irq_stat & q.irq_mask);

endmodule : xioe_top

//--- sim/xioe_ext_eq.sv
/*
  model of the external test equipment on the start, stop and event pins.
  assumes pins idle high on their pull-ups; a pulse pulls one pin low for len cycles.
*/
`timescale 1ns/10ps
module xioe_ext_eq (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic [1:0] sel,
  input wire logic [15:0] len,
  output logic event_in,
  output logic start_in,
  output logic stop_in,
  output logic busy
);
  typedef struct packed {
    logic [1:0] sel;
    logic [15:0] cnt;
  } xioe_eq_s;
  xioe_eq_s st_q, st_d;
  always_comb begin
    st_d = st_q;
    if (go) begin
      st_d.sel = sel;
      st_d.cnt = len;
    end else if (st_q.cnt != 16'h0) begin
      st_d.cnt = st_q.cnt - 16'h1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) st_q <= '0;
    else st_q <= st_d;
  end
  // a released pin floats back high on its pull-up
  assign busy = st_q.cnt != 16'h0;
  assign event_in = !(busy && st_q.sel == 2'h0);
  assign start_in = !(busy && st_q.sel == 2'h1);
  assign stop_in = !(busy && st_q.sel == 2'h2);
endmodule : xioe_ext_eq

//--- sim/xioe_top_chk.sv
/*
  assertions on the event, start/stop and event output ports of xioe_top.
  assumes the master offers write address and data in the same cycle.
*/
`timescale 1ns/10ps
module xioe_top_chk #(
  parameter int AW = 8,
  parameter int TRIG_END_CYC = 40,
  parameter int LOCKOUT_CYC = 30
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic event_out,
  input wire logic alarm_chan,
  input wire logic alarm_calc,
  input wire logic recording_active,
  input wire logic sweep_done,
  input wire logic cycle_event,
  input wire logic [10:0] cycle_event_comp,
  input wire logic trigger_arm,
  input wire logic start_req,
  input wire logic stop_req
);
  // ------
  // shadow of the control word and timers
  // ------
  typedef struct packed {
    logic [10:0] ctrl;
    int te;
    int lks;
    int lkp;
  } xioe_chk_s;
  xioe_chk_s st_q, st_d;
  logic wr_ctrl;
  logic [1:0] sel;
  logic [10:0] comp;
  assign wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign sel = st_q.ctrl[2:1];
  always_comb begin
    st_d = st_q;
    if (wr_ctrl && s_axi_awaddr == '0) st_d.ctrl = s_axi_wdata[10:0];
    if (sweep_done && st_q.ctrl[0] && st_q.ctrl[3]) st_d.te = TRIG_END_CYC;
    else if (st_q.te != 0) st_d.te = st_q.te - 1;
    if (start_req) st_d.lks = LOCKOUT_CYC;
    else if (st_q.lks != 0) st_d.lks = st_q.lks - 1;
    if (stop_req) st_d.lkp = LOCKOUT_CYC;
    else if (st_q.lkp != 0) st_d.lkp = st_q.lkp - 1;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) st_q <= '0;
    else st_q <= st_d;
  end
  always_comb begin
    case (st_q.ctrl[10:8])
      3'h1: comp = 11'h32;
      3'h2: comp = 11'h64;
      3'h3, 3'h4, 3'h5: comp = 11'hc8;
      default: comp = 11'h0;
    endcase
  end
  // ------
  // assertions
  // ------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_sel(v);
    sel == v ##1 sel == v;
  endsequence
  mode_route_a: assert property ((cycle_event || trigger_arm) |->
    trigger_arm == st_q.ctrl[0] && cycle_event != trigger_arm) else $error("event misrouted");
  alarm_out_a: assert property (s_sel(2'h0) |=>
    event_out == $past(alarm_chan || alarm_calc)) else $error("alarm output wrong");
  rec_out_a: assert property (s_sel(2'h1) |=>
    event_out == $past(recording_active)) else $error("recording output wrong");
  trig_end_a: assert property (s_sel(2'h2) ##1 sel == 2'h2 |->
    event_out == (st_q.te != 0)) else $error("trigger end pulse wrong");
  start_mode_a: assert property (start_req |->
    st_q.ctrl[5:4] inside {2'h1, 2'h2}) else $error("start while disabled");
  stop_mode_a: assert property (stop_req |->
    st_q.ctrl[7:6] inside {2'h1, 2'h2}) else $error("stop while disabled");
  start_lock_a: assert property (start_req |-> st_q.lks == 0)
    else $error("start inside lockout");
  stop_lock_a: assert property (stop_req |-> st_q.lkp == 0)
    else $error("stop inside lockout");
  comp_value_a: assert property (cycle_event |-> cycle_event_comp == comp)
    else $error("compensation wrong");
endmodule : xioe_top_chk

bind xioe_top xioe_top_chk #(.AW(AW), .TRIG_END_CYC(TRIG_END_CYC),
  .LOCKOUT_CYC(LOCKOUT_CYC)) chk (.clk_sys, .rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .event_out, .alarm_chan, .alarm_calc, .recording_active, .sweep_done, .cycle_event,
  .cycle_event_comp, .trigger_arm, .start_req, .stop_req);

//--- sim/external_io_event_conditioning_tb.sv
/*
  self-checking bench of xioe_top driven through axi4-lite and the equipment model.
  assumes timers shortened to 40 cycles trigger end and 30 cycles lockout.
*/
`timescale 1ns/10ps
module external_io_event_conditioning_tb;
  localparam int TE = 40;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic alarm_chan = 1'h0, alarm_calc = 1'h0, recording_active = 1'h0;
  logic sweep_done = 1'h0, acq_started = 1'h0, go = 1'h0;
  logic [1:0] psel = 2'h0;
  logic [15:0] plen = 16'h0;
  logic event_in, start_in, stop_in, awready, wready, bvalid, arready, rvalid;
  logic event_out, cycle_event, trigger_arm, start_req, stop_req, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [10:0] comp;
  int n_fail = 0;
  int check_count = 0;
  always #5 clk_sys = ~clk_sys;
  xioe_top #(.TRIG_END_CYC(TE), .LOCKOUT_CYC(30)) uut (.clk_sys, .rst,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .event_in, .start_in, .stop_in, .event_out, .alarm_chan, .alarm_calc, .recording_active,
    .sweep_done, .acq_started, .cycle_event, .cycle_event_comp(comp), .trigger_arm,
    .start_req, .stop_req, .irq);
  xioe_ext_eq eq (.clk_sys, .rst, .go, .sel(psel), .len(plen), .event_in, .start_in,
    .stop_in, .busy());
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        chk("bresp", er, bresp);
        break;
      end
    end
    chk("bvalid", 1'h1, bvalid);
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        chk("rdata", ed, rdata);
        chk("rresp", er, rresp);
        break;
      end
    end
    chk("rvalid", 1'h1, rvalid);
    rready <= 1'h0;
  endtask : rd
  task automatic pl(input logic [1:0] s, input logic [15:0] l);
    @(posedge clk_sys);
    psel <= s;
    plen <= l;
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
  endtask : pl
  // waits for a start, stop, cycle or arm pulse
  task automatic wt(input int w, input int lim, output logic s);
    logic [3:0] v;
    s = 1'h0;
    for (int n = 0; n < lim && !s; n++) begin
      @(posedge clk_sys);
      #1;
      v = {trigger_arm, cycle_event, stop_req, start_req};
      s = v[w];
    end
  endtask : wt
  task automatic lv(input logic [2:0] v, input logic e);
    @(posedge clk_sys);
    {alarm_chan, alarm_calc, recording_active} <= v;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("event_out", e, event_out);
  endtask : lv
  task automatic t_regs;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'(xioe_pkg::MIN_PULSE_CYC), 2'h0);
    rd(8'h10, 32'h0, 2'h0);
    rd(8'h20, 32'h0, xioe_pkg::RESP_SLVERR);
    wr(8'h20, 32'h1, xioe_pkg::RESP_SLVERR);
  endtask : t_regs
  task automatic t_start;
    logic s;
    pl(2'h1, 16'h3c);
    wt(0, 120, s);
    chk("start off", 1'h0, s);
    wr(8'h00, 32'h20, 2'h0);
    pl(2'h1, 16'h14);
    wt(0, 120, s);
    chk("start short", 1'h0, s);
    pl(2'h1, 16'h3c);
    wt(0, 120, s);
    chk("start fall", 1'h1, s);
    wr(8'h00, 32'h10, 2'h0);
    repeat (40) @(posedge clk_sys);
    pl(2'h1, 16'h3c);
    wt(0, 200, s);
    chk("start rise", 1'h1, s);
    wr(8'h04, 32'h5, 2'h0);
    rd(8'h04, 32'h5, 2'h0);
    wr(8'h00, 32'h20, 2'h0);
    repeat (40) @(posedge clk_sys);
    pl(2'h1, 16'ha);
    wt(0, 30, s);
    chk("start short width", 1'h1, s);
    pl(2'h1, 16'ha);
    wt(0, 40, s);
    chk("start locked", 1'h0, s);
    pl(2'h1, 16'ha);
    wt(0, 40, s);
    chk("start after lockout", 1'h1, s);
    wr(8'h00, 32'ha0, 2'h0);
    repeat (40) @(posedge clk_sys);
    pl(2'h1, 16'ha);
    wt(0, 30, s);
    chk("start before stop", 1'h1, s);
    pl(2'h2, 16'ha);
    wt(1, 60, s);
    chk("stop held", 1'h0, s);
    @(posedge clk_sys);
    acq_started <= 1'h1;
    @(posedge clk_sys);
    acq_started <= 1'h0;
    #1;
    chk("stop after acq", 1'h1, stop_req);
  endtask : t_start
  task automatic t_event;
    int nf[6] = '{0, 50, 100, 200, 500, 1000};
    logic s;
    for (int d = 0; d < 6; d++) begin
      wr(8'h00, 32'(d) << 8, 2'h0);
      pl(2'h0, 16'(nf[d] + 10));
      wt(2, 2 * nf[d] + 60, s);
      chk("cycle event", 1'h1, s);
      chk("comp", (nf[d] > 200) ? xioe_pkg::COMP_MAX_CYC : nf[d], comp);
    end
    wr(8'h00, 32'h200, 2'h0);
    pl(2'h0, 16'h32);
    wt(2, 300, s);
    chk("glitch", 1'h0, s);
    wr(8'h0c, 32'h1f, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    pl(2'h0, 16'ha);
    wt(3, 40, s);
    chk("arm", 1'h1, s);
    chk("irq masked", 1'h0, irq);
    rd(8'h0c, 32'h2, 2'h0);
    wr(8'h10, 32'h2, 2'h0);
    @(posedge clk_sys);
    #1;
    chk("irq", 1'h1, irq);
    wr(8'h0c, 32'h2, 2'h0);
    @(posedge clk_sys);
    #1;
    chk("irq cleared", 1'h0, irq);
  endtask : t_event
  task automatic t_out;
    int n;
    wr(8'h00, 32'h0, 2'h0);
    lv(3'h4, 1'h1);
    lv(3'h2, 1'h1);
    lv(3'h1, 1'h0);
    wr(8'h00, 32'h2, 2'h0);
    lv(3'h1, 1'h1);
    lv(3'h6, 1'h0);
    lv(3'h0, 1'h0);
    wr(8'h00, 32'hd, 2'h0);
    sweep_done <= 1'h1;
    @(posedge clk_sys);
    sweep_done <= 1'h0;
    n = 0;
    repeat (TE + 20) begin
      #1;
      if (event_out === 1'h1) n++;
      @(posedge clk_sys);
    end
    chk("trig end width", TE, n);
  endtask : t_out
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs();
    t_start();
    t_event();
    t_out();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule : external_io_event_conditioning_tb
